/* rtl/tmr_event_counter.sv */
// 8-bit timer/event counter with avalon-mm registers
// Operation
// - timer and pulse modes use prescaled clock
// - prescale select divides source by 2^code
// - mode field: 01 event, 10 timer, 11 pulse
// - counter advances only while enable set
// - timer mode counts prescaled clock falling edges
// - event mode counts pin edge per edge select
// - overflow reloads preload, raises interrupt, continues
// - preload write while disabled loads counter
// - preload write while running updates preload only
// - count register read returns live counter
// - edge select defines pulse gate polarity
// - prescale ignored while pin clocks counter
// - timer overflow in sleep still wakes
// - event counting continues in sleep, wakes
// - pulse mode waits for starting edge
// - pulse end clears enable, ignores pin
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counter
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic [tmr_pkg::ADDR_W-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic prescaler_source_tick,
  input wire logic ext_count_pin,
  output logic overflow_pulse,
  output logic wake_request,
  output logic irq
);
  import tmr_pkg::*;

  // =====================================
  // state
  logic [7:0] control_q;
  logic [7:0] control_d;
  logic [7:0] count_q;
  logic [7:0] count_d;
  logic [7:0] preload_q;
  logic [7:0] preload_d;
  logic [1:0] status_q;
  logic [1:0] status_d;
  logic [1:0] mask_q;
  logic [1:0] mask_d;
  logic armed_q;
  logic armed_d;
  logic gate_q;
  logic gate_d;
  logic pin_meta_q;
  logic pin_sync_q;
  logic pin_prev_q;
  logic ack_q;
  logic ack_d;
  logic [31:0] rdata_d;
  logic ovf_d;
  logic irq_d;
  logic psc_tick;
  logic rise;
  logic fall;
  logic start_edge;
  logic stop_edge;
  logic step;
  logic enable;
  logic edge_sel;
  mode_t mode;
  logic wr_ctl;
  logic wr_cnt;
  logic wr_sts;
  logic wr_msk;
  logic [1:0] events;

  assign mode = mode_t'(control_q[BIT_MODE_HI:BIT_MODE_LO]);
  assign enable = control_q[BIT_ENABLE];
  assign edge_sel = control_q[BIT_EDGE];

  // =====================================
  // prescaler
  tmr_prescaler #(.EXP_MAX(PSC_MAX_EXP)) u_psc
  (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .src_tick(prescaler_source_tick),
    .sel(control_q[BIT_PSC_HI:BIT_PSC_LO]),
    .tick(psc_tick)
  );

  // =====================================
  // pin synchroniser and edges
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      pin_meta_q <= 1'b0;
      pin_sync_q <= 1'b0;
      pin_prev_q <= 1'b0;
    end
    else
    begin
      pin_meta_q <= ext_count_pin;
      pin_sync_q <= pin_meta_q;
      pin_prev_q <= pin_sync_q;
    end
  end

  assign rise = pin_sync_q & ~pin_prev_q;
  assign fall = ~pin_sync_q & pin_prev_q;
  assign start_edge = edge_sel ? rise : fall;
  assign stop_edge = edge_sel ? fall : rise;

  // =====================================
  // bus decode
  assign wr_ctl = avs_write & ~ack_q & (avs_address == OFF_CONTROL) & avs_byteenable[0];
  assign wr_cnt = avs_write & ~ack_q & (avs_address == OFF_COUNT) & avs_byteenable[0];
  assign wr_sts = avs_write & ~ack_q & (avs_address == OFF_IRQ_STATUS) & avs_byteenable[0];
  assign wr_msk = avs_write & ~ack_q & (avs_address == OFF_IRQ_MASK) & avs_byteenable[0];

  // =====================================
  // counter and control
  always_comb
  begin
    control_d = control_q;
    count_d = count_q;
    preload_d = preload_q;
    armed_d = armed_q;
    gate_d = gate_q;
    step = 1'b0;
    ovf_d = 1'b0;
    events = 2'h0;
    case (mode)
      MODE_TIMER:
      begin
        step = enable & psc_tick;
      end
      MODE_EVENT:
      begin
        step = enable & (edge_sel ? fall : rise);
      end
      MODE_PULSE:
      begin
        step = enable & gate_q & psc_tick;
        if (enable & armed_q & start_edge)
        begin
          gate_d = 1'b1;
          armed_d = 1'b0;
        end
        else if (enable & gate_q & stop_edge)
        begin
          gate_d = 1'b0;
          step = 1'b0;
          control_d[BIT_ENABLE] = 1'b0;
          events[IRQ_PWM_DONE] = 1'b1;
        end
      end
      default:
      begin
        step = 1'b0;
      end
    endcase
    if (step)
    begin
      if (count_q == COUNT_FULL)
      begin
        count_d = preload_q;
        ovf_d = 1'b1;
        events[IRQ_OVF] = 1'b1;
      end
      else
      begin
        count_d = count_q + 8'h01;
      end
    end
    if (wr_cnt)
    begin
      preload_d = avs_writedata[7:0];
      if (!enable)
      begin
        count_d = avs_writedata[7:0];
      end
    end
    if (wr_ctl)
    begin
      control_d = avs_writedata[7:0] & CONTROL_WMASK;
      // arming happens on each software enable in pulse mode
      armed_d = avs_writedata[BIT_ENABLE];
      gate_d = 1'b0;
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      control_q <= CONTROL_RESET;
      count_q <= COUNT_RESET;
      preload_q <= COUNT_RESET;
      armed_q <= 1'b0;
      gate_q <= 1'b0;
      overflow_pulse <= 1'b0;
      wake_request <= 1'b0;
    end
    else
    begin
      control_q <= control_d;
      count_q <= count_d;
      preload_q <= preload_d;
      armed_q <= armed_d;
      gate_q <= gate_d;
      overflow_pulse <= ovf_d;
      wake_request <= ovf_d;
    end
  end

  // =====================================
  // interrupt status and mask
  always_comb
  begin
    status_d = status_q;
    mask_d = mask_q;
    if (wr_sts)
    begin
      status_d = status_q & ~avs_writedata[1:0];
    end
    status_d = status_d | events;
    if (wr_msk)
    begin
      mask_d = avs_writedata[1:0] & IRQ_BITS_MASK;
    end
    irq_d = |(status_d & mask_d);
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      status_q <= 2'h0;
      mask_q <= 2'h0;
      irq <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      mask_q <= mask_d;
      irq <= irq_d;
    end
  end

  // =====================================
  // avalon slave: one wait cycle, answer on second
  always_comb
  begin
    ack_d = (avs_read | avs_write) & ~ack_q;
    rdata_d = 32'h0000_0000;
    case (avs_address)
      OFF_CONTROL: rdata_d[7:0] = control_q;
      OFF_COUNT: rdata_d[7:0] = count_q;
      OFF_IRQ_STATUS: rdata_d[1:0] = status_q;
      OFF_IRQ_MASK: rdata_d[1:0] = mask_q;
      default: rdata_d[7:0] = UNMAPPED_READ;
    endcase
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      ack_q <= 1'b0;
      avs_readdata <= 32'h0000_0000;
      avs_waitrequest <= 1'b1;
    end
    else
    begin
      ack_q <= ack_d;
      avs_readdata <= rdata_d;
      avs_waitrequest <= ~ack_d;
    end
  end

  // =====================================
  // checks
  a_ovf_reload: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (step && count_q == COUNT_FULL) |=> (count_q == $past(preload_q) || $past(wr_cnt)))
    else $error("overflow did not reload preload");
  a_ovf_pulse: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (overflow_pulse && !ovf_d) |=> !overflow_pulse)
    else $error("overflow pulse longer than one cycle");
  a_stop_no_count: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (!enable && !wr_cnt) |=> count_q == $past(count_q))
    else $error("counter moved while disabled");
  a_load_idle: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_cnt && !enable) |=> count_q == $past(avs_writedata[7:0]))
    else $error("idle preload write not loaded");
  a_load_running: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (wr_cnt && enable && !step) |=> count_q == $past(count_q))
    else $error("running preload write changed counter");
  a_pulse_end: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == MODE_PULSE && enable && gate_q && stop_edge && !wr_ctl) |=> !enable)
    else $error("pulse end did not clear enable");
  a_pulse_wait: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == MODE_PULSE && !gate_q) |-> !step)
    else $error("pulse mode counted before start edge");
  a_event_edge: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == MODE_EVENT && enable && !wr_cnt && count_q != COUNT_FULL && (edge_sel ? fall : rise))
    |=> count_q == $past(count_q) + 8'h01)
    else $error("event edge not counted");
  a_timer_tick: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (mode == MODE_TIMER && !psc_tick && !wr_cnt) |=> count_q == $past(count_q))
    else $error("timer counted without prescaled tick");
  a_read_live: assert property (@(posedge ref_clk) disable iff (sys_rst)
    (avs_read && !ack_q && avs_address == OFF_COUNT) |=> avs_readdata[7:0] == $past(count_q))
    else $error("count read not live counter");
endmodule
`default_nettype wire

/* rtl/tmr_pkg.sv */
// package: register map, fields, modes and timing for the 8-bit timer/event counter
package tmr_pkg;
  localparam int ADDR_W = 4;
  localparam logic [ADDR_W-1:0] OFF_CONTROL = 4'h0;
  localparam logic [ADDR_W-1:0] OFF_COUNT = 4'h4;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 4'h8;
  localparam logic [ADDR_W-1:0] OFF_IRQ_MASK = 4'hC;
  localparam int BIT_MODE_HI = 7;
  localparam int BIT_MODE_LO = 6;
  localparam int BIT_ENABLE = 4;
  localparam int BIT_EDGE = 3;
  localparam int BIT_PSC_HI = 2;
  localparam int BIT_PSC_LO = 0;
  localparam int IRQ_OVF = 0;
  localparam int IRQ_PWM_DONE = 1;
  localparam logic [1:0] IRQ_BITS_MASK = 2'h3;
  localparam logic [7:0] CONTROL_RESET = 8'h08;
  localparam logic [7:0] CONTROL_WMASK = 8'hDF;
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] COUNT_FULL = 8'hFF;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;
  localparam int PSC_MAX_EXP = 7;
  typedef enum logic [1:0]
  {
    MODE_UNUSED = 2'h0,
    MODE_EVENT = 2'h1,
    MODE_TIMER = 2'h2,
    MODE_PULSE = 2'h3
  } mode_t;
endpackage

/* rtl/tmr_prescaler.sv */
// prescaler: divides the source-clock enable by 2^sel, one-cycle tick out
`timescale 1ns/10ps
`default_nettype none
module tmr_prescaler
#(
  parameter int EXP_MAX = 7
)
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic src_tick,
  input wire logic [2:0] sel,
  output logic tick
);
  import tmr_pkg::*;
  logic [EXP_MAX-1:0] div_q;
  logic [EXP_MAX-1:0] div_d;
  logic tick_d;
  logic [EXP_MAX:0] wide;
  logic [EXP_MAX:0] full;
  logic [EXP_MAX-1:0] low_mask;

  // =====================================
  // divider chain
  always_comb
  begin
    div_d = div_q;
    tick_d = 1'b0;
    wide = {1'b0, div_q} + {{EXP_MAX{1'b0}}, 1'b1};
    full = ({{EXP_MAX{1'b0}}, 1'b1} << sel);
    low_mask = full[EXP_MAX-1:0] - {{(EXP_MAX-1){1'b0}}, 1'b1};
    if (src_tick)
    begin
      // falling edge of divided clock: low bits all ones before wrap
      if ((div_q & low_mask) == low_mask)
      begin
        tick_d = 1'b1;
      end
      div_d = wide[EXP_MAX-1:0];
    end
  end

  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      div_q <= '0;
      tick <= 1'b0;
    end
    else
    begin
      div_q <= div_d;
      tick <= tick_d;
    end
  end
endmodule
`default_nettype wire

/* bench/pin_model.sv */
// partner model: drives pulses onto the external count pin
`timescale 1ns/10ps
`default_nettype none
module pin_model
(
  input wire logic ref_clk,
  input wire logic sys_rst,
  input wire logic start,
  input wire logic idle_lvl,
  input wire logic [7:0] n_edges,
  input wire logic [7:0] width,
  output logic ext_count_pin,
  output logic busy
);
  logic [8:0] left_q;
  logic [7:0] tmr_q;
  logic phase_q;
  assign ext_count_pin = idle_lvl ^ phase_q;
  assign busy = (left_q != 9'h000);
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      left_q <= 9'h000;
      tmr_q <= 8'h00;
      phase_q <= 1'b0;
    end
    else if (start)
    begin
      left_q <= {n_edges, 1'b0};
      tmr_q <= width;
    end
    else if (busy && tmr_q == 8'h00)
    begin
      phase_q <= ~phase_q;
      left_q <= left_q - 9'h001;
      tmr_q <= width;
    end
    else if (busy)
      tmr_q <= tmr_q - 8'h01;
  end
endmodule
`default_nettype wire

/* bench/tmr_event_counter_tb_top.sv */
// testbench: timer/event counter registers, modes and pin behaviour
`timescale 1ns/10ps
`default_nettype none
module tmr_event_counter_tb_top;
  import tmr_pkg::*;
  logic ref_clk, sys_rst, avs_read, avs_write, avs_waitrequest, start, idle_lvl, busy;
  logic ext_count_pin, overflow_pulse, wake_request, irq;
  logic [3:0] avs_address;
  logic [31:0] avs_writedata, avs_readdata, rd, rd2;
  logic [7:0] n_edges, width;
  int err_total, comparisons, gap;
  tmr_event_counter u_tmr_event_counter (.ref_clk(ref_clk), .sys_rst(sys_rst), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .prescaler_source_tick(1'b1),
    .ext_count_pin(ext_count_pin), .overflow_pulse(overflow_pulse), .wake_request(wake_request), .irq(irq));
  pin_model u_pin_model (.ref_clk(ref_clk), .sys_rst(sys_rst), .start(start), .idle_lvl(idle_lvl),
    .n_edges(n_edges), .width(width), .ext_count_pin(ext_count_pin), .busy(busy));
  // ==========
  // shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      err_total++;
      $display("MISMATCH t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    avs_read <= !wr;
    avs_write <= wr;
    avs_address <= a;
    avs_writedata <= {24'h000000, d};
    do @(posedge ref_clk); while (avs_waitrequest !== 1'b0);
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask
  task automatic wait_ovf();
    gap = 0;
    do
    begin
      @(negedge ref_clk);
      gap++;
    end
    while (overflow_pulse !== 1'b1);
    check(wake_request, 1'b1);
    @(negedge ref_clk);
    check(overflow_pulse, 1'b0);
  endtask
  task automatic pulses(input logic lvl, input logic [7:0] n, input logic [7:0] w);
    @(posedge ref_clk);
    idle_lvl <= lvl;
    n_edges <= n;
    width <= w;
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    @(posedge ref_clk);
    while (busy === 1'b1) @(posedge ref_clk);
    repeat (8) @(posedge ref_clk);
  endtask
  task automatic end_of_test();
    if (err_total == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  // ==========
  // scenarios
  task automatic t_reset();
    logic [31:0] exp [5] = '{32'h08, 32'h00, 32'h00, 32'h00, 32'h00};
    logic [3:0] adr [5] = '{OFF_CONTROL, OFF_COUNT, OFF_IRQ_STATUS, OFF_IRQ_MASK, 4'h2};
    for (int i = 0; i < 5; i++)
    begin
      bus(1'b0, adr[i], 8'h00);
      check(rd, exp[i]);
    end
  endtask
  task automatic t_timer();
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, OFF_CONTROL, 8'h00);
      bus(1'b1, OFF_COUNT, 8'hFC);
      bus(1'b0, OFF_COUNT, 8'h00);
      check(rd, 32'hFC);
      bus(1'b1, OFF_CONTROL, 8'h90 | i[7:0]);
      wait_ovf();
      wait_ovf();
      check(gap + 1, 4 << i);
    end
    bus(1'b1, OFF_COUNT, 8'h80);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd, 32'hFC);
    bus(1'b1, OFF_CONTROL, 8'h90);
    wait_ovf();
    wait_ovf();
    check(gap + 1, 128);
    bus(1'b0, OFF_COUNT, 8'h00);
    rd2 = rd;
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd != rd2, 1'b1);
  endtask
  task automatic t_irq();
    bus(1'b1, OFF_CONTROL, 8'h00);
    bus(1'b0, OFF_IRQ_STATUS, 8'h00);
    check(rd, 32'h1);
    check(irq, 1'b0);
    bus(1'b1, OFF_IRQ_MASK, 8'h01);
    check(irq, 1'b1);
    bus(1'b1, OFF_IRQ_MASK, 8'h00);
    check(irq, 1'b0);
    bus(1'b1, OFF_IRQ_MASK, 8'h01);
    bus(1'b1, OFF_IRQ_STATUS, 8'h01);
    @(negedge ref_clk);
    check(irq, 1'b0);
    bus(1'b0, OFF_IRQ_STATUS, 8'h00);
    check(rd, 32'h0);
  endtask
  task automatic t_event();
    bus(1'b1, OFF_CONTROL, 8'h00);
    bus(1'b1, OFF_COUNT, 8'h00);
    bus(1'b1, OFF_CONTROL, 8'h57);
    pulses(1'b0, 8'd5, 8'd3);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd, 32'h5);
    bus(1'b1, OFF_CONTROL, 8'h00);
    bus(1'b1, OFF_COUNT, 8'h00);
    bus(1'b1, OFF_CONTROL, 8'h58);
    pulses(1'b0, 8'd5, 8'd3);
    bus(1'b1, OFF_CONTROL, 8'h48);
    pulses(1'b0, 8'd3, 8'd3);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd, 32'h5);
  endtask
  task automatic t_pulse();
    bus(1'b1, OFF_CONTROL, 8'h00);
    bus(1'b1, OFF_COUNT, 8'h00);
    pulses(1'b1, 8'd0, 8'd0);
    bus(1'b1, OFF_CONTROL, 8'hD0);
    repeat (20) @(posedge ref_clk);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd, 32'h0);
    pulses(1'b1, 8'd1, 8'd40);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd >= 38 && rd <= 44, 1'b1);
    rd2 = rd;
    bus(1'b0, OFF_CONTROL, 8'h00);
    check(rd, 32'hC0);
    bus(1'b0, OFF_IRQ_STATUS, 8'h00);
    check(rd, 32'h2);
    pulses(1'b1, 8'd1, 8'd40);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd, rd2);
    bus(1'b1, OFF_COUNT, 8'h00);
    pulses(1'b0, 8'd0, 8'd0);
    bus(1'b1, OFF_CONTROL, 8'hD8);
    pulses(1'b0, 8'd1, 8'd20);
    bus(1'b0, OFF_COUNT, 8'h00);
    check(rd >= 18 && rd <= 24, 1'b1);
    bus(1'b0, OFF_CONTROL, 8'h00);
    check(rd, 32'hC8);
  endtask
  // ==========
  // clock, reset, run
  initial
  begin
    ref_clk = 1'b0;
    forever #2 ref_clk = ~ref_clk;
  end
  initial
  begin
    #200000;
    err_total++;
    end_of_test();
  end
  initial
  begin
    sys_rst = 1'b1;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h00000000;
    start = 1'b0;
    idle_lvl = 1'b0;
    n_edges = 8'h00;
    width = 8'h00;
    err_total = 0;
    comparisons = 0;
    repeat (6) @(posedge ref_clk);
    sys_rst <= 1'b0;
    t_reset();
    t_timer();
    t_irq();
    t_event();
    t_pulse();
    end_of_test();
  end
endmodule
`default_nettype wire
